// [src/msr_pkg.sv]
/*
 * Package for the subtract/rotate/special-page execution datapath:
 * operation codes, flag vector layout, reset values and the carrier structs.
 * Assumes the decoder presents one decoded operation per cycle.
 */
package msr_pkg;

   // operation select, driven by the instruction decoder
   typedef enum logic [2:0]
   {
      MSR_OP_NONE                  = 3'h0,
      MSR_OP_ROTATE_RIGHT_CARRY_OP = 3'h1,
      MSR_OP_REG_SUB_BORROW_OP     = 3'h2,
      MSR_OP_IMM_SUB_BORROW_OP     = 3'h3,
      MSR_OP_IMM_SUB_OP            = 3'h4,
      MSR_OP_SPECIAL_PAGE_STORE_OP = 3'h5,
      MSR_OP_SPECIAL_PAGE_LOAD_OP  = 3'h6,
      MSR_OP_HALT_OP               = 3'h7
   } msr_op_e;

   // widths
   localparam int MSR_DATA_W   = 8;
   localparam int MSR_FADDR_W  = 6;
   localparam int MSR_SIDX_W   = 4;
   localparam int MSR_SFR_NUM  = 16;
   localparam int MSR_WDT_W    = 8;
   localparam int MSR_PRE_W    = 8;

   // bit positions inside a byte
   localparam int MSR_BIT_MSB  = 7;
   localparam int MSR_BIT_LSB  = 0;
   localparam int MSR_NIB_MSB  = 3;

   // destination select encoding
   localparam logic MSR_DEST_ACC = 1'b0;
   localparam logic MSR_DEST_REG = 1'b1;

   // reset values
   localparam logic [7:0] MSR_ACC_RST      = 8'h00;
   localparam logic       MSR_CARRY_RST    = 1'b0;
   localparam logic       MSR_HALF_RST     = 1'b0;
   localparam logic       MSR_ZERO_RST     = 1'b0;
   localparam logic       MSR_TO_N_RST     = 1'b1;
   localparam logic       MSR_PD_N_RST     = 1'b1;
   localparam logic [7:0] MSR_SFR_RST      = 8'h00;
   localparam logic [7:0] MSR_WDT_CLR_VAL  = 8'h00;

   // decoded instruction from the decoder
   typedef struct packed
   {
      logic                   valid;
      msr_op_e                op;
      logic                   dest_sel;
      logic [MSR_FADDR_W-1:0] faddr;
      logic [MSR_SIDX_W-1:0]  sidx;
      logic [MSR_DATA_W-1:0]  imm;
   } msr_instr_s;

   // status flags held by the datapath
   typedef struct packed
   {
      logic zero_flag;
      logic half_carry_flag;
      logic carry_flag;
      logic timeout_flag_n;
      logic powerdown_flag_n;
   } msr_flags_s;

   // write-back to the file register array
   typedef struct packed
   {
      logic                   we;
      logic [MSR_FADDR_W-1:0] addr;
      logic [MSR_DATA_W-1:0]  data;
   } msr_fwr_s;

endpackage : msr_pkg

// [src/msr_sfr_page.sv]
/*
 * Special-function register page: sixteen bytes, one write port, registered read.
 * Assumes read index is presented one cycle before its data is needed.
 */
`timescale 1ns/1ps

module msr_sfr_page
   import msr_pkg::*;
(
   // clock and reset
   input  wire logic                  clk_sys,
   input  wire logic                  nrst,
   // write port
   input  wire logic                  wr_en,
   input  wire logic [MSR_SIDX_W-1:0] wr_idx,
   input  wire logic [MSR_DATA_W-1:0] wr_data,
   // read port
   input  wire logic [MSR_SIDX_W-1:0] rd_idx,
   output logic      [MSR_DATA_W-1:0] rd_data
);

   logic [MSR_DATA_W-1:0] mem_q [MSR_SFR_NUM];
   logic [MSR_DATA_W-1:0] mem_d [MSR_SFR_NUM];
   logic [MSR_DATA_W-1:0] rd_d;

   ////////////////////////////////////////////////////////////////////////////
   // next contents; read sees old value on a same-cycle write
   always_comb
   begin
      for (int i = 0; i < MSR_SFR_NUM; i++)
      begin
         mem_d[i] = mem_q[i];
      end
      if (wr_en)
      begin
         mem_d[wr_idx] = wr_data;
      end
      rd_d = mem_q[rd_idx];
   end

   always_ff @(posedge clk_sys or negedge nrst)
   begin
      if (!nrst)
      begin
         for (int i = 0; i < MSR_SFR_NUM; i++)
         begin
            mem_q[i] <= MSR_SFR_RST;
         end
         rd_data <= MSR_SFR_RST;
      end
      else
      begin
         mem_q   <= mem_d;
         rd_data <= rd_d;
      end
   end

endmodule : msr_sfr_page

// [src/msr_alu.sv]
/*
 * Execution datapath for rotate-right through carry, the subtract group,
 * special-page moves and halt entry. Holds the accumulator and flags.
 * Assumes the decoder gives the file register operand with the instruction,
 * and prefetches the special-page read index one cycle early (sfr_rd_idx).
 * The watchdog and halt hardware sit elsewhere and only see the three pulses.
 */
`timescale 1ns/1ps

// Summary of operation
// - rotate right: old carry into bit 7, bit 0 into carry, one cycle.
// - destination bit 0 writes accumulator, 1 writes the file register back.
// - register subtract-with-borrow: reg + ~acc + carry, sets zero, half-carry, carry.
// - immediate subtract-with-borrow: imm + ~acc + carry into accumulator, flags set.
// - immediate subtract: imm - acc into accumulator, one cycle, flags set.
// - special-page store copies accumulator into indexed register, flags unchanged.
// - special-page load copies indexed register into accumulator, flags unchanged.
// - halt entry clears watchdog counter and first prescaler in one cycle, then halts.
// - halt entry sets timeout flag high, clears powerdown flag, nothing else.
module msr_alu
   import msr_pkg::*;
(
   // clock and reset
   input  wire logic                  clk_sys,
   input  wire logic                  nrst,
   // decoded instruction and operand
   input  wire msr_instr_s            instr,
   input  wire logic [MSR_DATA_W-1:0] freg_data,
   input  wire logic [MSR_SIDX_W-1:0] sfr_rd_idx,
   // file register write-back
   output msr_fwr_s                   fwr,
   // architectural state
   output logic      [MSR_DATA_W-1:0] accumulator,
   output msr_flags_s                 flags,
   // watchdog and halt control
   output logic                       wdt_clear,
   output logic                       first_prescaler_clear,
   output logic                       halt_req
);

   ////////////////////////////////////////////////////////////////////////////
   // adder result with the two carries that feed the flags
   typedef struct packed
   {
      logic [MSR_DATA_W-1:0] sum;
      logic                  c7;
      logic                  c3;
   } msr_sum_s;

   // a + b + cin with carries out of bits 3 and 7
   function automatic msr_sum_s msr_add3(input logic [MSR_DATA_W-1:0] a,
                                         input logic [MSR_DATA_W-1:0] b,
                                         input logic                  cin);
      logic [4:0] lo;
      logic [4:0] hi;
      msr_sum_s   r;
      lo    = {1'b0, a[MSR_NIB_MSB:0]} + {1'b0, b[MSR_NIB_MSB:0]} + {4'h0, cin};
      hi    = {1'b0, a[MSR_BIT_MSB:4]} + {1'b0, b[MSR_BIT_MSB:4]} + {4'h0, lo[4]};
      r.sum = {hi[3:0], lo[3:0]};
      r.c3  = lo[4];
      r.c7  = hi[4];
      return r;
   endfunction : msr_add3

   // ops whose result obeys the destination bit; immediates always go to acc
   function automatic logic msr_is_freg_op(input msr_op_e op);
      return (op == MSR_OP_ROTATE_RIGHT_CARRY_OP) || (op == MSR_OP_REG_SUB_BORROW_OP);
   endfunction : msr_is_freg_op

   ////////////////////////////////////////////////////////////////////////////
   // next values and datapath intermediates
   logic [MSR_DATA_W-1:0] acc_d;
   msr_flags_s            flags_d;
   msr_fwr_s              fwr_d;
   logic                  wdt_clear_d;
   logic                  pre_clear_d;
   logic                  halt_d;
   logic                  sfr_we;
   logic [MSR_DATA_W-1:0] sfr_rd_data;
   msr_sum_s              add_r;
   logic [MSR_DATA_W-1:0] result;
   logic                  is_sub;

   ////////////////////////////////////////////////////////////////////////////
   // special-page storage; read is prefetched so load still takes one cycle
   // registered read keeps the page a plain memory, at the price of the prefetch
   msr_sfr_page u_sfr_page
   (
      .clk_sys (clk_sys),
      .nrst    (nrst),
      .wr_en   (sfr_we),
      .wr_idx  (instr.sidx),
      .wr_data (accumulator),
      .rd_idx  (sfr_rd_idx),
      .rd_data (sfr_rd_data)
   );

   assign sfr_we = instr.valid && (instr.op == MSR_OP_SPECIAL_PAGE_STORE_OP);

   ////////////////////////////////////////////////////////////////////////////
   // limitation: a load right after a store to the same index sees the old byte,
   // because its data were fetched during the store; the decoder leaves one gap
   // next-state for accumulator, flags, write-back and halt strobes
   always_comb
   begin
      acc_d       = accumulator;
      flags_d     = flags;
      fwr_d       = '{we: 1'b0, addr: instr.faddr, data: fwr.data};
      wdt_clear_d = 1'b0;
      pre_clear_d = 1'b0;
      halt_d      = 1'b0;
      result      = freg_data;
      is_sub      = 1'b0;
      add_r       = msr_add3(freg_data, ~accumulator, flags.carry_flag);
      if (instr.valid)
      begin
         unique case (instr.op)
            MSR_OP_ROTATE_RIGHT_CARRY_OP:
            begin
               // only carry moves; zero and half-carry are left alone
               result           = {flags.carry_flag, freg_data[MSR_BIT_MSB:1]};
               flags_d.carry_flag = freg_data[MSR_BIT_LSB];
            end
            MSR_OP_REG_SUB_BORROW_OP:
            begin
               add_r  = msr_add3(freg_data, ~accumulator, flags.carry_flag);
               is_sub = 1'b1;
            end
            MSR_OP_IMM_SUB_BORROW_OP:
            begin
               add_r  = msr_add3(instr.imm, ~accumulator, flags.carry_flag);
               is_sub = 1'b1;
            end
            MSR_OP_IMM_SUB_OP:
            begin
               // two's complement subtract: imm + ~acc + 1
               add_r  = msr_add3(instr.imm, ~accumulator, 1'b1);
               is_sub = 1'b1;
            end
            MSR_OP_SPECIAL_PAGE_STORE_OP:
            begin
               // the byte itself is written by the page module
               result = accumulator;
            end
            MSR_OP_SPECIAL_PAGE_LOAD_OP:
            begin
               // flags are left alone on purpose
               acc_d = sfr_rd_data;
            end
            MSR_OP_HALT_OP:
            begin
               // pulses plus timeout and powerdown flags; the watchdog acts on the pulses the cycle after
               wdt_clear_d              = 1'b1;
               pre_clear_d              = 1'b1;
               halt_d                   = 1'b1;
               flags_d.timeout_flag_n   = 1'b1;
               flags_d.powerdown_flag_n = 1'b0;
            end
            MSR_OP_NONE:
            begin
               result = freg_data;
            end
         endcase
         // one flag update shared by the whole subtract group
         if (is_sub)
         begin
            result                  = add_r.sum;
            flags_d.carry_flag      = add_r.c7;
            flags_d.half_carry_flag = add_r.c3;
            flags_d.zero_flag       = (add_r.sum == 8'h00);
         end
         // file-register ops honour the destination bit, immediates always go to acc
         if (msr_is_freg_op(instr.op))
         begin
            if (instr.dest_sel == MSR_DEST_REG)
            begin
               fwr_d.we   = 1'b1;
               fwr_d.data = result;
            end
            else
            begin
               acc_d = result;
            end
         end
         else if ((instr.op == MSR_OP_IMM_SUB_BORROW_OP) ||
                  (instr.op == MSR_OP_IMM_SUB_OP))
         begin
            acc_d = result;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // state registers; every output comes straight from here
   // reset loads package constants into accumulator and flags, zeros into the other outputs
   always_ff @(posedge clk_sys or negedge nrst)
   begin
      if (!nrst)
      begin
         accumulator           <= MSR_ACC_RST;
         flags                 <= '{zero_flag:        MSR_ZERO_RST,
                                    half_carry_flag:  MSR_HALF_RST,
                                    carry_flag:       MSR_CARRY_RST,
                                    timeout_flag_n:   MSR_TO_N_RST,
                                    powerdown_flag_n: MSR_PD_N_RST};
         fwr                   <= '0;
         wdt_clear             <= 1'b0;
         first_prescaler_clear <= 1'b0;
         halt_req              <= 1'b0;
      end
      else
      begin
         accumulator           <= acc_d;
         flags                 <= flags_d;
         fwr                   <= fwr_d;
         wdt_clear             <= wdt_clear_d;
         first_prescaler_clear <= pre_clear_d;
         halt_req              <= halt_d;
      end
   end

endmodule : msr_alu

// [tb/msr_freg_model.sv]
/*
 * File register array model standing beside the execution datapath.
 * Assumes the bench preloads one location before the first operand read.
 */
`timescale 1ns/1ps

module msr_freg_model
   import msr_pkg::*;
(
   // clock
   input  wire logic                   clk_sys,
   // operand read
   input  wire logic [MSR_FADDR_W-1:0] faddr,
   output logic      [MSR_DATA_W-1:0]  freg_data,
   // write-back and preload
   input  wire msr_fwr_s               fwr,
   input  wire logic                   ld_en,
   input  wire logic [MSR_FADDR_W-1:0] ld_addr,
   input  wire logic [MSR_DATA_W-1:0]  ld_data
);
   logic [MSR_DATA_W-1:0] mem_q [64];

   // preload wins over write-back, the bench never overlaps them
   always_ff @(posedge clk_sys)
   begin
      if (ld_en)
         mem_q[ld_addr] <= ld_data;
      else if (fwr.we)
         mem_q[fwr.addr] <= fwr.data;
   end

   // bypass the pending write so back-to-back ops see the new value
   assign freg_data = (fwr.we && fwr.addr == faddr) ? fwr.data : mem_q[faddr];
endmodule : msr_freg_model

// [tb/msr_alu_assertions.sv]
/*
 * Concurrent checks on the datapath ports, bound into msr_alu.
 * Assumes one clock domain and the active-low asynchronous reset.
 */
`timescale 1ns/1ps

module msr_alu_assertions
   import msr_pkg::*;
(
   // clock and reset
   input  wire logic                  clk_sys,
   input  wire logic                  nrst,
   // inputs
   input  wire msr_instr_s            instr,
   input  wire logic [MSR_DATA_W-1:0] freg_data,
   input  wire logic [MSR_SIDX_W-1:0] sfr_rd_idx,
   // outputs
   input  wire msr_fwr_s              fwr,
   input  wire logic [MSR_DATA_W-1:0] accumulator,
   input  wire msr_flags_s            flags,
   input  wire logic                  wdt_clear,
   input  wire logic                  first_prescaler_clear,
   input  wire logic                  halt_req
);
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!nrst);

   // issue strobes per operation
   wire is_rot = instr.valid && instr.op == MSR_OP_ROTATE_RIGHT_CARRY_OP;
   wire is_rsb = instr.valid && instr.op == MSR_OP_REG_SUB_BORROW_OP;
   wire is_isb = instr.valid && instr.op == MSR_OP_IMM_SUB_BORROW_OP;
   wire is_isub = instr.valid && instr.op == MSR_OP_IMM_SUB_OP;
   wire is_st = instr.valid && instr.op == MSR_OP_SPECIAL_PAGE_STORE_OP;
   wire is_ld = instr.valid && instr.op == MSR_OP_SPECIAL_PAGE_LOAD_OP;
   wire is_halt = instr.valid && instr.op == MSR_OP_HALT_OP;

   // halt entry is issue then the three pulses together
   sequence s_halt_issue;
      is_halt;
   endsequence
   sequence s_halt_done;
      wdt_clear && first_prescaler_clear && halt_req;
   endsequence

   chk_halt_clear: assert property (s_halt_issue |=> s_halt_done)
      else $error("halt pulses missing");
   chk_halt_cause: assert property ($rose(halt_req) |-> $past(is_halt))
      else $error("halt pulse without halt op");
   chk_halt_flags: assert property (s_halt_issue |=> flags.timeout_flag_n
      && !flags.powerdown_flag_n && $stable({flags.zero_flag, flags.half_carry_flag,
      flags.carry_flag})) else $error("halt flag update wrong");
   chk_rot_result: assert property (is_rot |=> flags.carry_flag == $past(freg_data[0])
      && $stable({flags.zero_flag, flags.half_carry_flag})
      && (($past(instr.dest_sel) ? fwr.data : accumulator)
      == {$past(flags.carry_flag), $past(freg_data[7:1])})) else $error("rotate wrong");
   chk_dest_select: assert property ((is_rot || is_rsb) |=> fwr.we == $past(instr.dest_sel)
      && (!fwr.we || fwr.addr == $past(instr.faddr))) else $error("destination wrong");
   chk_reg_borrow: assert property (is_rsb && !instr.dest_sel |=>
      {flags.carry_flag, accumulator} == {1'b0, $past(freg_data)}
      + {1'b0, ~$past(accumulator)} + $past(flags.carry_flag)) else $error("reg sub wrong");
   chk_imm_borrow: assert property (is_isb |=> {flags.carry_flag, accumulator}
      == {1'b0, $past(instr.imm)} + {1'b0, ~$past(accumulator)} + $past(flags.carry_flag))
      else $error("imm sub borrow wrong");
   chk_imm_sub: assert property (is_isub |=> {flags.carry_flag, accumulator}
      == {1'b0, $past(instr.imm)} + {1'b0, ~$past(accumulator)} + 9'h001)
      else $error("imm sub wrong");
   chk_half_zero: assert property ((is_isb || is_isub) |=>
      (flags.zero_flag == (accumulator == 8'h00)) && (flags.half_carry_flag
      == (({1'b0, $past(instr.imm[3:0])} + {1'b0, ~$past(accumulator[3:0])}
      + ($past(flags.carry_flag) | $past(is_isub))) > 5'h0F))) else $error("zero/half wrong");
   chk_move_flags: assert property ((is_st || is_ld) |=> $stable(flags) && !fwr.we)
      else $error("move touched flags");
   chk_store_acc: assert property (is_st |=> $stable(accumulator))
      else $error("store changed accumulator");
endmodule : msr_alu_assertions

bind msr_alu msr_alu_assertions msr_alu_assertions_inst (.clk_sys, .nrst, .instr,
   .freg_data, .sfr_rd_idx, .fwr, .accumulator, .flags, .wdt_clear,
   .first_prescaler_clear, .halt_req);

// [tb/msr_alu_tb_top.sv]
/*
 * Self-checking bench: issues decoded ops and compares against a shadow model.
 * Assumes file register 03h is the only operand location used.
 */
`timescale 1ns/1ps

module msr_alu_tb_top
   import msr_pkg::*;
;
   logic clk_sys, nrst, wdt_clear, first_prescaler_clear, halt_req, ld_en;
   msr_instr_s instr;
   msr_fwr_s   fwr;
   msr_flags_s flags;
   logic [3:0] sfr_rd_idx;
   logic [7:0] freg_data, accumulator, e_acc, e_reg, e_sfr [16];
   logic       e_c, e_h, e_z, e_to, e_pd;
   int         errors, tests_run;

   msr_alu msr_alu_inst (.clk_sys, .nrst, .instr, .freg_data, .sfr_rd_idx, .fwr,
      .accumulator, .flags, .wdt_clear, .first_prescaler_clear, .halt_req);
   msr_freg_model msr_freg_model_inst (.clk_sys, .faddr(instr.faddr), .freg_data, .fwr,
      .ld_en, .ld_addr(6'h03), .ld_data(8'hA5));

   // 50 MHz clock
   initial clk_sys = 1'b0;
   always #10 clk_sys = ~clk_sys;

   task chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
      tests_run++;
      if (seen !== exp)
      begin
         errors++;
         $display("Error %s expected %h seen %h", nm, exp, seen);
      end
   endtask : chk

   task finish_test;
      if (errors == 0 && tests_run > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask : finish_test

   // issue one op, update the shadow state, compare after the taking edge
   task exec(input msr_op_e op, input logic d, input logic [7:0] v, input logic [3:0] s);
      logic [7:0] src, res;
      logic [8:0] sum;
      logic [4:0] hs;
      logic       cin, fw;
      instr <= '{1'b1, op, d, 6'h03, s, v};
      sfr_rd_idx <= s;
      src = (op inside {MSR_OP_ROTATE_RIGHT_CARRY_OP, MSR_OP_REG_SUB_BORROW_OP}) ? e_reg : v;
      cin = (op == MSR_OP_IMM_SUB_OP) ? 1'b1 : e_c;
      sum = {1'b0, src} + {1'b0, ~e_acc} + cin;
      hs = {1'b0, src[3:0]} + {1'b0, ~e_acc[3:0]} + cin;
      fw = 1'b0;
      res = e_acc;
      case (op)
         MSR_OP_ROTATE_RIGHT_CARRY_OP:
         begin
            res = {e_c, src[7:1]};
            e_c = src[0];
            fw  = d;
         end
         MSR_OP_REG_SUB_BORROW_OP, MSR_OP_IMM_SUB_BORROW_OP, MSR_OP_IMM_SUB_OP:
         begin
            res = sum[7:0];
            e_c = sum[8];
            e_h = hs[4];
            e_z = (sum[7:0] == 8'h00);
            fw = d && op == MSR_OP_REG_SUB_BORROW_OP;
         end
         MSR_OP_SPECIAL_PAGE_STORE_OP: e_sfr[s] = e_acc;
         MSR_OP_SPECIAL_PAGE_LOAD_OP: res = e_sfr[s];
         MSR_OP_HALT_OP:
         begin
            e_to = 1'b1;
            e_pd = 1'b0;
         end
         default: ;
      endcase
      if (fw) e_reg = res; else e_acc = res;
      @(posedge clk_sys);
      #1;
      chk("accumulator", accumulator, e_acc);
      chk("flags", flags, {e_z, e_h, e_c, e_to, e_pd});
      chk("file register", freg_data, e_reg);
      chk("clear pulses", {wdt_clear, first_prescaler_clear, halt_req},
          {3{op == MSR_OP_HALT_OP}});
   endtask : exec

   // about thirty cycles of work, over six times that before giving up
   initial
   begin
      #(200 * 20);
      errors++;
      finish_test;
   end

   initial
   begin
      nrst = 1'b0; instr = '0; sfr_rd_idx = 4'h0; ld_en = 1'b0; errors = 0; tests_run = 0;
      e_acc = 8'h00; e_reg = 8'hA5; e_c = 1'b0; e_h = 1'b0; e_z = 1'b0; e_to = 1'b1; e_pd = 1'b1;
      e_sfr = '{default: 8'h00};
      repeat (10) @(posedge clk_sys);
      #1 nrst = 1'b1;
      ld_en = 1'b1;
      chk("reset accumulator", accumulator, MSR_ACC_RST);
      chk("reset flags", flags,
          {MSR_ZERO_RST, MSR_HALF_RST, MSR_CARRY_RST, MSR_TO_N_RST, MSR_PD_N_RST});
      @(posedge clk_sys);
      #1 ld_en = 1'b0;
      exec(MSR_OP_ROTATE_RIGHT_CARRY_OP, 1'b1, 8'h00, 4'h0);
      exec(MSR_OP_ROTATE_RIGHT_CARRY_OP, 1'b0, 8'h00, 4'h0);
      exec(MSR_OP_IMM_SUB_OP, 1'b0, 8'hA9, 4'h0);
      exec(MSR_OP_IMM_SUB_OP, 1'b0, 8'h06, 4'h0);
      exec(MSR_OP_IMM_SUB_BORROW_OP, 1'b0, 8'h05, 4'h0);
      exec(MSR_OP_IMM_SUB_BORROW_OP, 1'b0, 8'h00, 4'h0);
      exec(MSR_OP_REG_SUB_BORROW_OP, 1'b1, 8'h00, 4'h0);
      exec(MSR_OP_REG_SUB_BORROW_OP, 1'b0, 8'h00, 4'h0);
      exec(MSR_OP_REG_SUB_BORROW_OP, 1'b1, 8'h00, 4'h0);
      exec(MSR_OP_SPECIAL_PAGE_STORE_OP, 1'b0, 8'h00, 4'hF);
      exec(MSR_OP_IMM_SUB_OP, 1'b0, 8'h3C, 4'hF);
      exec(MSR_OP_SPECIAL_PAGE_LOAD_OP, 1'b0, 8'h00, 4'hF);
      exec(MSR_OP_SPECIAL_PAGE_STORE_OP, 1'b0, 8'h00, 4'h0);
      // gap cycle prefetches the index that the next load reads
      exec(MSR_OP_NONE, 1'b0, 8'h00, 4'h0);
      exec(MSR_OP_SPECIAL_PAGE_LOAD_OP, 1'b0, 8'h00, 4'h0);
      exec(MSR_OP_SPECIAL_PAGE_LOAD_OP, 1'b0, 8'h00, 4'h0);
      exec(MSR_OP_HALT_OP, 1'b0, 8'h00, 4'h0);
      exec(MSR_OP_NONE, 1'b0, 8'h00, 4'h0);
      instr.valid <= 1'b0;
      @(posedge clk_sys);
      finish_test;
   end
endmodule : msr_alu_tb_top
